// [shared/pfbu_defines.svh]
// Constants of the program flow branch unit: widths, flag positions, offsets, cycle counts
`ifndef PFBU_DEFINES_SVH
`define PFBU_DEFINES_SVH

`define PFBU_PC_W 22
`define PFBU_SP_W 16
`define PFBU_CNT_W 3

// Status flag bit positions
`define PFBU_FLAG_C 3'd0
`define PFBU_FLAG_Z 3'd1
`define PFBU_FLAG_N 3'd2
`define PFBU_FLAG_V 3'd3
`define PFBU_FLAG_H 3'd5
`define PFBU_FLAG_I 3'd7

// Register byte offsets on the bus
`define PFBU_OFS_FLAGS 8'h00
`define PFBU_OFS_EXT_HIGH 8'h04
`define PFBU_OFS_STACK_PTR 8'h08
`define PFBU_OFS_PC 8'h0c
`define PFBU_OFS_STATE 8'h10

// Reset values
`define PFBU_RST_FLAGS 8'h00
`define PFBU_RST_EXT_HIGH 8'h00
`define PFBU_RST_STACK_PTR 16'hffff
`define PFBU_RST_PC 22'h000000

// Cycle counts per instruction
`define PFBU_CYC_ONE 3'h1
`define PFBU_CYC_JUMP 3'h2
`define PFBU_CYC_CALL_IND 3'h4
`define PFBU_CYC_CALL_DIR 3'h5
`define PFBU_CYC_RETURN 3'h5
`define PFBU_CYC_SKIP_ONE 3'h2
`define PFBU_CYC_SKIP_TWO 3'h3
`define PFBU_CYC_BR_TAKEN 3'h2

// Return address bytes moved through the stack, and PC step sizes
`define PFBU_STK_BYTES 2'h3
`define PFBU_PC_STEP_ONE 22'h000001
`define PFBU_PC_STEP_TWO 22'h000002
`define PFBU_PC_STEP_THREE 22'h000003

`endif

// [shared/pfbu_pkg.sv]
// Types of the program flow branch unit
package pfbu_pkg;

  typedef enum logic [4:0] {
    sequential_op = 5'h00,
    indirect_jump_op = 5'h01,
    extended_indirect_jump_op = 5'h02,
    indirect_call_op = 5'h03,
    extended_indirect_call_op = 5'h04,
    direct_call_op = 5'h05,
    subroutine_return_op = 5'h06,
    interrupt_return_op = 5'h07,
    compare_skip_equal_op = 5'h08,
    register_compare_op = 5'h09,
    compare_with_borrow_op = 5'h0a,
    compare_immediate_op = 5'h0b,
    skip_reg_bit_clear_op = 5'h0c,
    skip_reg_bit_one_op = 5'h0d,
    skip_io_bit_clear_op = 5'h0e,
    skip_io_bit_one_op = 5'h0f,
    branch_flag_one_op = 5'h10,
    branch_flag_clear_op = 5'h11,
    branch_equal_op = 5'h12
  } pfbu_op_t;

  typedef enum logic [1:0] {
    PFBU_ST_IDLE = 2'b01,
    PFBU_ST_RUN = 2'b10
  } pfbu_state_t;

  // One decoded instruction as handed over by the fetch stage
  typedef struct packed {
    pfbu_op_t op;
    logic [7:0] immediate;
    logic [2:0] bitSel;
    logic [6:0] offset;
    logic [21:0] target;
  } pfbu_instr_t;

  typedef struct packed {
    logic [21:0] addr;
    logic [7:0] data;
  } pfbu_stack_word_t;

endpackage

// [rtl/pfbu_compare.sv]
// Subtract-and-discard comparator producing the arithmetic status flags
`timescale 1ns/1ps
`default_nettype none
`include "pfbu_defines.svh"

module pfbu_compare (
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic useCarry,
  input wire logic [7:0] flagsIn,
  output logic [7:0] flagsOut
);

  logic borrowIn;
  logic [8:0] diff;
  logic [7:0] res;

  assign borrowIn = useCarry & flagsIn[`PFBU_FLAG_C];
  assign diff = {1'b0, opA} - {1'b0, opB} - {8'h00, borrowIn};
  assign res = diff[7:0];

  always_comb
  begin
    flagsOut = flagsIn;
    flagsOut[`PFBU_FLAG_C] = diff[8];
    // With borrow, a zero result only keeps Z so multi-byte compares chain
    flagsOut[`PFBU_FLAG_Z] = (res == 8'h00) & (~useCarry | flagsIn[`PFBU_FLAG_Z]);
    flagsOut[`PFBU_FLAG_N] = res[7];
    flagsOut[`PFBU_FLAG_V] = (opA[7] & ~opB[7] & ~res[7]) | (~opA[7] & opB[7] & res[7]);
    flagsOut[`PFBU_FLAG_H] = (~opA[3] & opB[3]) | (opB[3] & res[3]) | (res[3] & ~opA[3]);
  end

endmodule // pfbu_compare
`default_nettype wire

// [rtl/pfbu_flow_unit.sv]
// Program flow branch unit: jumps, calls, returns, compares, skips and branches
// Operation
// - Indirect jump loads PC from pointer pair, 2 cycles, flags untouched.
// - Extended indirect jump loads PC from high register over pointer, 2 cycles.
// - Indirect call goes to pointer pair address, 4 cycles, no flag change.
// - Extended indirect call goes to high register joined with pointer, 4 cycles.
// - Direct call loads PC with instruction constant, 5 cycles, flags kept.
// - Subroutine return reloads PC from stack, 5 cycles, flags kept.
// - Interrupt return reloads PC from stack, sets interrupt enable, 5 cycles.
// - Compare-skip-equal skips next instruction on match, 1/2/3 cycles, flags kept.
// - Register compare subtracts (and carry), updates Z N V C H, 1 cycle.
// - Immediate compare subtracts constant, updates Z N V C H, 1 cycle.
// - Register bit skip tests a bit, skips on clear or set, 1/2/3 cycles.
// - I/O bit skip tests an I/O bit, skips on clear or set, 1/2/3 cycles.
// - Flag branch adds offset plus one when flag matches; equal tests Z.
`timescale 1ns/1ps
`default_nettype none
`include "pfbu_defines.svh"

module pfbu_flow_unit (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic instValid,
  output logic instReady,
  input wire pfbu_pkg::pfbu_instr_t instIn,
  input wire logic [7:0] rdVal,
  input wire logic [7:0] rrVal,
  input wire logic [7:0] ioVal,
  input wire logic [15:0] zPtr,
  input wire logic nextTwoWord,
  output logic instDone,
  output logic [21:0] pcOut,
  output logic [7:0] flagsOut,
  output logic [15:0] stkAddr,
  output logic [7:0] stkWrData,
  output logic stkWe,
  output logic stkRe,
  input wire logic [7:0] stkRdData
);

  pfbu_pkg::pfbu_state_t state_q;
  logic [`PFBU_CNT_W-1:0] cycLeft_q;
  logic [`PFBU_PC_W-1:0] pc_q;
  logic [`PFBU_PC_W-1:0] target_q;
  logic [`PFBU_PC_W-1:0] retPc_q;
  logic [23:0] popAddr_q;
  logic [1:0] pushLeft_q;
  logic [1:0] popLeft_q;
  logic popWait_q;
  logic useStack_q;
  logic setIe_q;
  logic [7:0] flags_q;
  logic [7:0] extHigh_q;
  logic [`PFBU_SP_W-1:0] sp_q;
  logic done_q;

  logic take;
  logic finish;
  logic [`PFBU_CNT_W-1:0] cycNew;
  logic [`PFBU_PC_W-1:0] tgtNew;
  logic [`PFBU_PC_W-1:0] retNew;
  logic pushNew;
  logic popNew;
  logic cmpNew;
  logic cmpCarry;
  logic [7:0] cmpB;
  logic [7:0] cmpFlags;
  logic skipHit;
  logic brHit;
  logic [`PFBU_PC_W-1:0] pcNext1;
  logic [`PFBU_PC_W-1:0] pcSkip;
  logic [`PFBU_PC_W-1:0] brTarget;
  logic [23:0] extTarget;
  logic pushNow;
  logic popNow;

  // Bus side registers
  logic wrPend_q;
  logic [7:0] wrOfs_q;
  logic busTake;
  logic swFlagsWr;
  logic swExtWr;
  logic swSpWr;
  logic [31:0] readMux;

  assign take = instValid && (state_q == pfbu_pkg::PFBU_ST_IDLE);
  assign instReady = (state_q == pfbu_pkg::PFBU_ST_IDLE);
  assign finish = (state_q == pfbu_pkg::PFBU_ST_RUN) && (cycLeft_q == `PFBU_CYC_ONE);
  assign pushNow = (state_q == pfbu_pkg::PFBU_ST_RUN) && (pushLeft_q != 2'h0);
  assign popNow = (state_q == pfbu_pkg::PFBU_ST_RUN) && (popLeft_q != 2'h0);

  assign pcNext1 = pc_q + `PFBU_PC_STEP_ONE;
  // Skipped instruction length decides the jump over it
  assign pcSkip = pc_q + (nextTwoWord ? `PFBU_PC_STEP_THREE : `PFBU_PC_STEP_TWO);
  assign brTarget = pcNext1 + {{(`PFBU_PC_W-7){instIn.offset[6]}}, instIn.offset};
  // The joined address is wider than the PC; only the PC width is reachable
  assign extTarget = {extHigh_q, zPtr};

  pfbu_compare u_compare (
    .opA(rdVal),
    .opB(cmpB),
    .useCarry(cmpCarry),
    .flagsIn(flags_q),
    .flagsOut(cmpFlags)
  );

  always_comb
  begin
    skipHit = 1'b0;
    brHit = 1'b0;
    unique case (instIn.op)
      pfbu_pkg::compare_skip_equal_op: skipHit = (rdVal == rrVal);
      pfbu_pkg::skip_reg_bit_clear_op: skipHit = ~rrVal[instIn.bitSel];
      pfbu_pkg::skip_reg_bit_one_op: skipHit = rrVal[instIn.bitSel];
      pfbu_pkg::skip_io_bit_clear_op: skipHit = ~ioVal[instIn.bitSel];
      pfbu_pkg::skip_io_bit_one_op: skipHit = ioVal[instIn.bitSel];
      pfbu_pkg::branch_flag_one_op: brHit = flags_q[instIn.bitSel];
      pfbu_pkg::branch_flag_clear_op: brHit = ~flags_q[instIn.bitSel];
      pfbu_pkg::branch_equal_op: brHit = flags_q[`PFBU_FLAG_Z];
      default:
      begin
        skipHit = 1'b0;
        brHit = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    cycNew = `PFBU_CYC_ONE;
    tgtNew = pcNext1;
    retNew = pcNext1;
    pushNew = 1'b0;
    popNew = 1'b0;
    cmpNew = 1'b0;
    cmpCarry = 1'b0;
    cmpB = rrVal;
    unique case (instIn.op)
      pfbu_pkg::indirect_jump_op:
      begin
        cycNew = `PFBU_CYC_JUMP;
        tgtNew = {{(`PFBU_PC_W-16){1'b0}}, zPtr};
      end
      pfbu_pkg::extended_indirect_jump_op:
      begin
        cycNew = `PFBU_CYC_JUMP;
        tgtNew = extTarget[`PFBU_PC_W-1:0];
      end
      pfbu_pkg::indirect_call_op:
      begin
        cycNew = `PFBU_CYC_CALL_IND;
        tgtNew = {{(`PFBU_PC_W-16){1'b0}}, zPtr};
        pushNew = 1'b1;
      end
      pfbu_pkg::extended_indirect_call_op:
      begin
        cycNew = `PFBU_CYC_CALL_IND;
        tgtNew = extTarget[`PFBU_PC_W-1:0];
        pushNew = 1'b1;
      end
      pfbu_pkg::direct_call_op:
      begin
        cycNew = `PFBU_CYC_CALL_DIR;
        tgtNew = instIn.target;
        // Two-word call: the return lands after the constant word
        retNew = pc_q + `PFBU_PC_STEP_TWO;
        pushNew = 1'b1;
      end
      pfbu_pkg::subroutine_return_op, pfbu_pkg::interrupt_return_op:
      begin
        cycNew = `PFBU_CYC_RETURN;
        popNew = 1'b1;
      end
      pfbu_pkg::register_compare_op:
        cmpNew = 1'b1;
      pfbu_pkg::compare_with_borrow_op:
      begin
        cmpNew = 1'b1;
        cmpCarry = 1'b1;
      end
      pfbu_pkg::compare_immediate_op:
      begin
        cmpNew = 1'b1;
        cmpB = instIn.immediate;
      end
      pfbu_pkg::compare_skip_equal_op, pfbu_pkg::skip_reg_bit_clear_op,
      pfbu_pkg::skip_reg_bit_one_op, pfbu_pkg::skip_io_bit_clear_op,
      pfbu_pkg::skip_io_bit_one_op:
      begin
        if (skipHit)
        begin
          cycNew = nextTwoWord ? `PFBU_CYC_SKIP_TWO : `PFBU_CYC_SKIP_ONE;
          tgtNew = pcSkip;
        end
      end
      pfbu_pkg::branch_flag_one_op, pfbu_pkg::branch_flag_clear_op,
      pfbu_pkg::branch_equal_op:
      begin
        if (brHit)
        begin
          cycNew = `PFBU_CYC_BR_TAKEN;
          tgtNew = brTarget;
        end
      end
      default:
      begin
        cycNew = `PFBU_CYC_ONE;
      end
    endcase
  end

  // Sequencer: one instruction in flight, PC moves on its last edge
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_q <= pfbu_pkg::PFBU_ST_IDLE;
      cycLeft_q <= '0;
    end
    else if (take)
    begin
      state_q <= pfbu_pkg::PFBU_ST_RUN;
      cycLeft_q <= cycNew;
    end
    else if (finish)
    begin
      state_q <= pfbu_pkg::PFBU_ST_IDLE;
      cycLeft_q <= '0;
    end
    else if (state_q == pfbu_pkg::PFBU_ST_RUN)
    begin
      cycLeft_q <= cycLeft_q - `PFBU_CYC_ONE;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      target_q <= `PFBU_RST_PC;
      retPc_q <= `PFBU_RST_PC;
      useStack_q <= 1'b0;
      setIe_q <= 1'b0;
    end
    else if (take)
    begin
      target_q <= tgtNew;
      retPc_q <= retNew;
      useStack_q <= popNew;
      setIe_q <= (instIn.op == pfbu_pkg::interrupt_return_op);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      pc_q <= `PFBU_RST_PC;
    else if (finish)
      pc_q <= useStack_q ? popAddr_q[`PFBU_PC_W-1:0] : target_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      done_q <= 1'b0;
    else
      done_q <= finish;
  end

  // Stack traffic: low byte pushed first, so high byte pops first
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pushLeft_q <= 2'h0;
      popLeft_q <= 2'h0;
    end
    else if (take)
    begin
      pushLeft_q <= pushNew ? `PFBU_STK_BYTES : 2'h0;
      popLeft_q <= popNew ? `PFBU_STK_BYTES : 2'h0;
    end
    else
    begin
      if (pushNow)
        pushLeft_q <= pushLeft_q - 2'h1;
      if (popNow)
        popLeft_q <= popLeft_q - 2'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      popWait_q <= 1'b0;
      popAddr_q <= '0;
    end
    else
    begin
      popWait_q <= popNow;
      if (popWait_q)
        popAddr_q <= {popAddr_q[15:0], stkRdData};
    end
  end

  always_comb
  begin
    stkWrData = retPc_q[7:0];
    unique case (pushLeft_q)
      2'h2: stkWrData = retPc_q[15:8];
      2'h1: stkWrData = {{(24-`PFBU_PC_W){1'b0}}, retPc_q[`PFBU_PC_W-1:16]};
      default: stkWrData = retPc_q[7:0];
    endcase
  end

  // Push writes at the pointer then moves down; pop moves up then reads
  assign stkWe = pushNow;
  assign stkRe = popNow;
  assign stkAddr = popNow ? sp_q + 16'h0001 : sp_q;

  // AHB-Lite slave: zero wait states, always OKAY
  assign busTake = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign swFlagsWr = wrPend_q && (wrOfs_q == `PFBU_OFS_FLAGS);
  assign swExtWr = wrPend_q && (wrOfs_q == `PFBU_OFS_EXT_HIGH);
  assign swSpWr = wrPend_q && (wrOfs_q == `PFBU_OFS_STACK_PTR);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wrPend_q <= 1'b0;
      wrOfs_q <= 8'h00;
    end
    else
    begin
      wrPend_q <= busTake && hwrite && (haddr[31:8] == 24'h000000);
      wrOfs_q <= haddr[7:0];
    end
  end

  always_comb
  begin
    readMux = 32'h00000000;
    if (haddr[31:8] == 24'h000000)
    begin
      unique case (haddr[7:0])
        `PFBU_OFS_FLAGS: readMux = {24'h000000, flags_q};
        `PFBU_OFS_EXT_HIGH: readMux = {24'h000000, extHigh_q};
        `PFBU_OFS_STACK_PTR: readMux = {16'h0000, sp_q};
        `PFBU_OFS_PC: readMux = {{(32-`PFBU_PC_W){1'b0}}, pc_q};
        `PFBU_OFS_STATE: readMux = {31'h00000000, state_q == pfbu_pkg::PFBU_ST_RUN};
        default: readMux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      hrdata <= 32'h00000000;
    else if (busTake && !hwrite)
      hrdata <= readMux;
  end

  // Hardware flag updates override a software write in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      flags_q <= `PFBU_RST_FLAGS;
    else if (take && cmpNew)
      flags_q <= cmpFlags;
    else if (finish && setIe_q)
    begin
      flags_q <= swFlagsWr ? hwdata[7:0] : flags_q;
      flags_q[`PFBU_FLAG_I] <= 1'b1;
    end
    else if (swFlagsWr)
      flags_q <= hwdata[7:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      extHigh_q <= `PFBU_RST_EXT_HIGH;
    else if (swExtWr)
      extHigh_q <= hwdata[7:0];
  end

  // Stack moves by hardware win over a software pointer write
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      sp_q <= `PFBU_RST_STACK_PTR;
    else if (pushNow)
      sp_q <= sp_q - 16'h0001;
    else if (popNow)
      sp_q <= sp_q + 16'h0001;
    else if (swSpWr)
      sp_q <= hwdata[15:0];
  end

  assign instDone = done_q;
  assign pcOut = pc_q;
  assign flagsOut = flags_q;

endmodule // pfbu_flow_unit
`default_nettype wire

// [sim/pfbu_flow_props.sv]
// Concurrent checks on the ports of the flow unit
`timescale 1ns/1ps
`default_nettype none
module pfbu_flow_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic instValid,
  input wire logic instReady,
  input wire pfbu_pkg::pfbu_instr_t instIn,
  input wire logic [7:0] rdVal,
  input wire logic [7:0] rrVal,
  input wire logic [15:0] zPtr,
  input wire logic nextTwoWord,
  input wire logic instDone,
  input wire logic [21:0] pcOut,
  input wire logic [7:0] flagsOut,
  input wire logic [7:0] stkWrData,
  input wire logic stkWe,
  input wire logic stkRe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic take;
  logic isJump;
  logic isICall;
  pfbu_pkg::pfbu_op_t op;
  assign take = instValid && instReady;
  assign op = instIn.op;
  assign isJump = op == pfbu_pkg::indirect_jump_op || op == pfbu_pkg::extended_indirect_jump_op;
  assign isICall = op == pfbu_pkg::indirect_call_op || op == pfbu_pkg::extended_indirect_call_op;
  jump_time_a:
    assert property (take && isJump |-> ##2 !instDone ##1 instDone) else $error("jump length");
  jump_dest_a:
    assert property (take && op == pfbu_pkg::indirect_jump_op |-> ##3
      pcOut == {6'h00, $past(zPtr, 3)}) else $error("jump target");
  jump_flags_a:
    assert property (take && isJump |-> ##3 flagsOut == $past(flagsOut, 3))
      else $error("jump touched flags");
  indirect_call_op_time_a:
    assert property (take && isICall |-> ##4 !instDone ##1 instDone) else $error("indirect_call_op length");
  call_push_a:
    assert property (take && (isICall || op == pfbu_pkg::direct_call_op) |=>
      stkWe [*3] ##1 !stkWe) else $error("call push count");
  push_low_a:
    assert property (take && op == pfbu_pkg::indirect_call_op |=>
      stkWrData == 8'($past(pcOut) + 22'h1)) else $error("pushed low byte");
  ret_pop_a:
    assert property (take && (op == pfbu_pkg::subroutine_return_op ||
      op == pfbu_pkg::interrupt_return_op) |=> stkRe [*3] ##1 !stkRe ##1 !instDone ##1 instDone)
      else $error("return pop or length");
  interrupt_return_op_ie_a:
    assert property (take && op == pfbu_pkg::interrupt_return_op |-> ##6 flagsOut[7])
      else $error("interrupt enable not set");
  cmp_flags_a:
    assert property (take && op == pfbu_pkg::register_compare_op |=>
      flagsOut[1] == ($past(rdVal) == $past(rrVal)) &&
      flagsOut[0] == ($past(rdVal) < $past(rrVal)))
      else $error("compare flags");
  skip_two_a:
    assert property (take && op == pfbu_pkg::compare_skip_equal_op && rdVal == rrVal && nextTwoWord
      |-> ##3 !instDone ##1 instDone && pcOut == $past(pcOut, 4) + 22'h3) else $error("skip two");
  bus_okay_a:
    assert property (hreadyout && !hresp) else $error("bus answer not okay");
  cover property (take && op == pfbu_pkg::interrupt_return_op);
  cover property (take && op == pfbu_pkg::compare_skip_equal_op && nextTwoWord);
  cover property (take && op == pfbu_pkg::branch_flag_clear_op);
endmodule // pfbu_flow_props

bind pfbu_flow_unit pfbu_flow_props u_props (.sys_clk, .rst_n, .hreadyout, .hresp, .instValid,
  .instReady, .instIn, .rdVal, .rrVal, .zPtr, .nextTwoWord, .instDone, .pcOut, .flagsOut,
  .stkWrData, .stkWe, .stkRe);
`default_nettype wire

// [sim/pfbu_stack_model.sv]
// Behavioural return-address stack in data memory
`timescale 1ns/1ps
`default_nettype none
module pfbu_stack_model (
  input wire logic sys_clk,
  input wire logic [15:0] stkAddr,
  input wire logic [7:0] stkWrData,
  input wire logic stkWe,
  input wire logic stkRe,
  output logic [7:0] stkRdData
);
  logic [7:0] mem [0:65535];
  initial stkRdData = 8'h5a;
  always @(posedge sys_clk)
  begin
    if (stkWe)
    begin
      mem[stkAddr] <= stkWrData;
    end
    // Idle data toggles so a late sample never sees the popped byte
    stkRdData <= stkRe ? mem[stkAddr] : ~stkRdData;
  end
endmodule // pfbu_stack_model
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the program flow branch unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic instValid = 1'b0;
  pfbu_pkg::pfbu_instr_t instIn = '0;
  logic [7:0] rdVal = 8'h00, rrVal = 8'h00, ioVal = 8'h00, vA = 8'h00, vB = 8'h00;
  logic [7:0] vIo = 8'h00, im = 8'h00, x;
  logic [15:0] zPtr = 16'h0, vZ = 16'h0;
  logic nextTwoWord = 1'b0, tw = 1'b0, b;
  logic [2:0] bs = 3'h0;
  pfbu_pkg::pfbu_op_t sop;
  logic [6:0] of = 7'h0;
  logic [21:0] tg = 22'h0, ePc = 22'h0, pcOut;
  logic hreadyout, hresp, instReady, instDone, stkWe, stkRe;
  logic [31:0] hrdata;
  logic [7:0] flagsOut, stkWrData, stkRdData;
  logic [15:0] stkAddr;
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  pfbu_flow_unit DUT (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instValid(instValid),
    .instReady(instReady), .instIn(instIn), .rdVal(rdVal), .rrVal(rrVal), .ioVal(ioVal),
    .zPtr(zPtr), .nextTwoWord(nextTwoWord), .instDone(instDone), .pcOut(pcOut),
    .flagsOut(flagsOut), .stkAddr(stkAddr), .stkWrData(stkWrData), .stkWe(stkWe),
    .stkRe(stkRe), .stkRdData(stkRdData));
  pfbu_stack_model STK (.sys_clk(sys_clk), .stkAddr(stkAddr), .stkWrData(stkWrData),
    .stkWe(stkWe), .stkRe(stkRe), .stkRdData(stkRdData));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= 32'(a);
    // Ready and read data are taken at the rising edge that ends each phase
    do @(posedge sys_clk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (!hreadyout);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic mchk(input logic [15:0] a, input logic [7:0] e);
    chk({24'h0, STK.mem[a]}, {24'h0, e});
  endtask
  // Operands are staged in bench variables and reach the pins only on the issue edge
  task automatic exec(input pfbu_pkg::pfbu_op_t op, input int nCyc, input logic [21:0] pc);
    int n;
    @(posedge sys_clk);
    instValid <= 1'b1;
    instIn <= '{op, im, bs, of, tg};
    rdVal <= vA;
    rrVal <= vB;
    ioVal <= vIo;
    zPtr <= vZ;
    nextTwoWord <= tw;
    do @(negedge sys_clk); while (!instReady);
    @(posedge sys_clk);
    instValid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (!instDone && n < 12);
    chk(32'(n - 1), 32'(nCyc));
    chk({10'h0, pcOut}, {10'h0, pc});
    ePc = pc;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h008, 32'h0000ffff);
    wr(12'h00c, 32'h55);
    rd(12'h00c, 32'h0);
    wr(12'h100, 32'h77);
    rd(12'h100, 32'h0);
    rd(12'h010, 32'h0);
    wr(12'h004, 32'h2a);
    rd(12'h004, 32'h2a);
    wr(12'h000, 32'h41);
    $display("test registers done");
    vZ = 16'h1234;
    exec(pfbu_pkg::indirect_jump_op, 2, 22'h001234);
    vZ = 16'h0100;
    exec(pfbu_pkg::extended_indirect_jump_op, 2, 22'h2a0100);
    rd(12'h000, 32'h41);
    $display("test jumps done");
    vZ = 16'h0200;
    exec(pfbu_pkg::indirect_call_op, 4, 22'h000200);
    vZ = 16'h0300;
    exec(pfbu_pkg::extended_indirect_call_op, 4, 22'h2a0300);
    tg = 22'h3abcde;
    exec(pfbu_pkg::direct_call_op, 5, 22'h3abcde);
    mchk(16'hffff, 8'h01);
    mchk(16'hfffd, 8'h2a);
    mchk(16'hfffa, 8'h00);
    mchk(16'hfff9, 8'h02);
    rd(12'h008, 32'h0000fff6);
    exec(pfbu_pkg::subroutine_return_op, 5, 22'h2a0302);
    exec(pfbu_pkg::subroutine_return_op, 5, 22'h000201);
    rd(12'h000, 32'h41);
    exec(pfbu_pkg::interrupt_return_op, 5, 22'h2a0101);
    rd(12'h000, 32'hc1);
    $display("test calls done");
    vA = 8'h05;
    vB = 8'h05;
    exec(pfbu_pkg::register_compare_op, 1, ePc + 22'h1);
    rd(12'h000, 32'hc2);
    vA = 8'h03;
    exec(pfbu_pkg::register_compare_op, 1, ePc + 22'h1);
    rd(12'h000, 32'he5);
    vA = 8'h80;
    im = 8'h01;
    exec(pfbu_pkg::compare_immediate_op, 1, ePc + 22'h1);
    rd(12'h000, 32'he8);
    wr(12'h000, 32'h03);
    vA = 8'h05;
    vB = 8'h04;
    exec(pfbu_pkg::compare_with_borrow_op, 1, ePc + 22'h1);
    rd(12'h000, 32'h02);
    $display("test compares done");
    // Wrong-source bits are inverted so reading the other operand flips the outcome
    for (int k = 0; k < 4; k++)
      for (int m = 0; m < 3; m++)
      begin
        bs = 3'(k + 3);
        b = (m != 0) ? k[0] : ~k[0];
        x = b ? (8'h1 << bs) : ~(8'h1 << bs);
        vB = (k > 1) ? ~x : x;
        vIo = (k > 1) ? x : ~x;
        tw = (m == 2);
        sop = pfbu_pkg::pfbu_op_t'(5'(12 + k));
        exec(sop, m + 1, ePc + 22'(m + 1));
      end
    vA = 8'h77;
    vB = 8'h77;
    exec(pfbu_pkg::compare_skip_equal_op, 3, ePc + 22'h3);
    vB = 8'h76;
    exec(pfbu_pkg::compare_skip_equal_op, 1, ePc + 22'h1);
    rd(12'h000, 32'h02);
    $display("test skips done");
    bs = 3'h0;
    of = 7'h7e;
    exec(pfbu_pkg::branch_flag_one_op, 1, ePc + 22'h1);
    exec(pfbu_pkg::branch_flag_clear_op, 2, ePc - 22'h1);
    of = 7'h10;
    exec(pfbu_pkg::branch_equal_op, 2, ePc + 22'h11);
    bs = 3'h1;
    of = 7'h3f;
    exec(pfbu_pkg::branch_flag_one_op, 2, ePc + 22'h40);
    exec(pfbu_pkg::branch_flag_clear_op, 1, ePc + 22'h1);
    $display("test branches done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
